/* core/sfcf_flags.sv */
`timescale 1ns/1ps
`include "sfcf_defs.svh"


module sfcf_flags
    import sfcf_pkg::*;
(
    // apb clock and reset
    input  wire logic                  pclk,
    input  wire logic                  presetn,
    // apb slave
    input  wire logic                  psel,
    input  wire logic                  penable,
    input  wire logic                  pwrite,
    input  wire logic [`SFCF_AW-1:0]   paddr,
    input  wire logic [31:0]           pwdata,
    input  wire logic [3:0]            pstrb,
    output logic      [31:0]           prdata,
    output logic                       pready,
    output logic                       pslverr,
    // supply monitor detectors, low while the fault stands
    input  wire logic                  analog_supply_overvoltage_n,
    input  wire logic                  analog_supply_undervoltage_n,
    input  wire logic                  io_supply_overvoltage_n,
    input  wire logic                  io_supply_undervoltage_n,
    input  wire logic                  core_supply_overvoltage_n,
    input  wire logic                  core_supply_undervoltage_n,
    input  wire logic                  analog_supply_oscillation_n,
    input  wire logic                  io_supply_oscillation_n,
    input  wire logic                  core_supply_oscillation_n,
    input  wire logic                  analog_regulator_hot_n,
    input  wire logic                  io_regulator_hot_n,
    input  wire logic                  analog_regulator_limit_n,
    input  wire logic                  io_regulator_limit_n,
    input  wire logic                  ground_a_open_n,
    input  wire logic                  ground_b_open_n,
    input  wire logic                  digital_ground_open_n,
    // clock monitor detectors, low while the fault stands
    input  wire logic                  main_clock_freq_fault_n,
    input  wire logic                  diag_oscillator_watchdog_n,
    input  wire logic                  main_clock_watchdog_n,
    // interrupt
    output logic                       irq
);

    // ==========================================================
    // detector inputs gathered in register bit order
    logic [`SFCF_NSUP-1:0] sup_raw;
    logic [`SFCF_NCLK-1:0] clk_raw;
    logic [`SFCF_NEV-1:0]  ev_raw;

    assign sup_raw[`SFCF_A_OV]    = analog_supply_overvoltage_n;
    assign sup_raw[`SFCF_A_UV]    = analog_supply_undervoltage_n;
    assign sup_raw[`SFCF_IO_OV]   = io_supply_overvoltage_n;
    assign sup_raw[`SFCF_IO_UV]   = io_supply_undervoltage_n;
    assign sup_raw[`SFCF_C_OV]    = core_supply_overvoltage_n;
    assign sup_raw[`SFCF_C_UV]    = core_supply_undervoltage_n;
    assign sup_raw[`SFCF_A_OSC]   = analog_supply_oscillation_n;
    assign sup_raw[`SFCF_IO_OSC]  = io_supply_oscillation_n;
    assign sup_raw[`SFCF_C_OSC]   = core_supply_oscillation_n;
    assign sup_raw[`SFCF_A_HOT]   = analog_regulator_hot_n;
    assign sup_raw[`SFCF_IO_HOT]  = io_regulator_hot_n;
    assign sup_raw[`SFCF_A_LIM]   = analog_regulator_limit_n;
    assign sup_raw[`SFCF_IO_LIM]  = io_regulator_limit_n;
    assign sup_raw[`SFCF_GA_OPEN] = ground_a_open_n;
    assign sup_raw[`SFCF_GB_OPEN] = ground_b_open_n;
    assign sup_raw[`SFCF_GD_OPEN] = digital_ground_open_n;

    assign clk_raw[`SFCF_MCK_FREQ] = main_clock_freq_fault_n;
    assign clk_raw[`SFCF_DOSC_WD]  = diag_oscillator_watchdog_n;
    assign clk_raw[`SFCF_MCK_WD]   = main_clock_watchdog_n;

    // irq status and mask share this layout: clock flags on top
    assign ev_raw = {clk_raw, sup_raw};

    // ==========================================================
    // state
    sfcf_state_s state_reg;
    sfcf_state_s state_next;

    // ==========================================================
    // fault detection after three-stage synchroniser
    // detectors are analog and asynchronous; a fault counts only once
    // stages two and three agree, so a single metastable sample is ignored
    logic [`SFCF_NEV-1:0] fault_det;

    genvar gi;
    generate
        for (gi = 0; gi < `SFCF_NEV; gi = gi + 1) begin : g_det
            assign fault_det[gi] = ~state_reg.sync2[gi] & ~state_reg.sync3[gi];
        end
    endgenerate

    logic [`SFCF_NSUP-1:0] sup_det;
    logic [`SFCF_NCLK-1:0] clk_det;

    assign sup_det = fault_det[`SFCF_NSUP-1:0];
    assign clk_det = fault_det[`SFCF_NEV-1:`SFCF_NSUP];

    // ==========================================================
    // apb decode
    logic setup_ph;
    logic access_ph;
    logic hit_sup;
    logic hit_clk;
    logic hit_irq;
    logic hit_msk;
    logic hit_any;
    logic wr_en;

    assign setup_ph  = psel & ~penable;
    assign access_ph = psel & penable;
    assign hit_sup   = (paddr == `SFCF_SUP_ADDR);
    assign hit_clk   = (paddr == `SFCF_CLK_ADDR);
    assign hit_irq   = (paddr == `SFCF_IRQ_ADDR);
    assign hit_msk   = (paddr == `SFCF_MSK_ADDR);
    assign hit_any   = hit_sup | hit_clk | hit_irq | hit_msk;
    assign wr_en     = access_ph & pwrite & hit_any;

    // zero wait states; read data is loaded during the setup cycle
    assign pready  = 1'b1;
    assign pslverr = access_ph & ~hit_any;
    assign prdata  = state_reg.rdata;

    // write data limited to the enabled byte lanes
    logic [31:0] wr_bits;

    generate
        for (gi = 0; gi < 4; gi = gi + 1) begin : g_lane
            assign wr_bits[gi*8 +: 8] = pwdata[gi*8 +: 8] & {8{pstrb[gi]}};
        end
    endgenerate

    // one-hot style write-one masks per register
    logic [`SFCF_NSUP-1:0] sup_w1;
    logic [`SFCF_NCLK-1:0] clk_w1;
    logic [`SFCF_NEV-1:0]  irq_w1;

    assign sup_w1 = (wr_en & hit_sup) ? wr_bits[`SFCF_NSUP-1:0] : `SFCF_PAD;
    assign clk_w1 = (wr_en & hit_clk) ? wr_bits[`SFCF_NCLK-1:0] : {`SFCF_NCLK{1'b0}};
    assign irq_w1 = (wr_en & hit_irq) ? wr_bits[`SFCF_NEV-1:0] : `SFCF_EV_NONE;

    // ==========================================================
    // read mux
    logic [31:0] rd_val;

    always_comb begin
        rd_val = 32'h0000_0000;
        if (hit_sup) begin
            rd_val = {`SFCF_PAD, state_reg.supply};
        end else if (hit_clk) begin
            // reserved bits come out as the fixed pattern
            rd_val = {`SFCF_PAD, `SFCF_CLK_RSVD | {13'h0000, state_reg.clock}};
        end else if (hit_irq) begin
            rd_val = {13'h0000, state_reg.irq_status};
        end else if (hit_msk) begin
            rd_val = {13'h0000, state_reg.irq_mask};
        end
    end

    // ==========================================================
    // next state
    always_comb begin
        state_next = state_reg;

        state_next.sync1 = ev_raw;
        state_next.sync2 = state_reg.sync1;
        state_next.sync3 = state_reg.sync2;

        // write 1 restores no-fault, write 0 is ignored
        state_next.supply = state_reg.supply | sup_w1;
        state_next.clock  = state_reg.clock | clk_w1;

        // detection applied after the write so a standing fault wins
        state_next.supply = state_next.supply & ~sup_det;
        state_next.clock  = state_next.clock & ~clk_det;

        // irq status: write one to clear, a detection in the same cycle wins
        state_next.irq_status = (state_reg.irq_status & ~irq_w1) | fault_det;

        if (wr_en & hit_msk) begin
            state_next.irq_mask = wr_bits[`SFCF_NEV-1:0];
        end

        if (setup_ph & ~pwrite) begin
            state_next.rdata = rd_val;
        end
    end

    // ==========================================================
    // registers
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            state_reg.sync1      <= `SFCF_SYNC_IDLE;
            state_reg.sync2      <= `SFCF_SYNC_IDLE;
            state_reg.sync3      <= `SFCF_SYNC_IDLE;
            state_reg.supply     <= `SFCF_SUP_RST;
            state_reg.clock      <= `SFCF_CLK_FRST;
            state_reg.irq_status <= `SFCF_EV_NONE;
            state_reg.irq_mask   <= `SFCF_EV_NONE;
            state_reg.rdata      <= 32'h0000_0000;
        end else begin
            state_reg <= state_next;
        end
    end

    // ==========================================================
    // interrupt: level, high while any unmasked status bit stands
    assign irq = |(state_reg.irq_status & state_reg.irq_mask);

endmodule : sfcf_flags

/* core/sfcf_defs.svh */
`ifndef SFCF_DEFS_SVH
`define SFCF_DEFS_SVH

// ==========================================================
// sizes
`define SFCF_NSUP        16
`define SFCF_NCLK        3
`define SFCF_NEV         19
`define SFCF_AW          8
`define SFCF_PAD         16'h0000

// ==========================================================
// register indices and byte addresses (index times four)
`define SFCF_SUP_IDX     8'h03
`define SFCF_CLK_IDX     8'h04
`define SFCF_IRQ_IDX     8'h08
`define SFCF_MSK_IDX     8'h09
`define SFCF_SUP_ADDR    (`SFCF_SUP_IDX << 2)
`define SFCF_CLK_ADDR    (`SFCF_CLK_IDX << 2)
`define SFCF_IRQ_ADDR    (`SFCF_IRQ_IDX << 2)
`define SFCF_MSK_ADDR    (`SFCF_MSK_IDX << 2)

// ==========================================================
// reset values and fixed patterns
`define SFCF_SUP_RST     16'hffff
`define SFCF_CLK_RST     16'hfc07
`define SFCF_CLK_RSVD    16'hfc00
`define SFCF_CLK_FRST    3'h7
`define SFCF_EV_NONE     19'h00000
`define SFCF_SYNC_IDLE   19'h7ffff

// ==========================================================
// supply flag bit positions
`define SFCF_A_OV        15
`define SFCF_A_UV        14
`define SFCF_IO_OV       13
`define SFCF_IO_UV       12
`define SFCF_C_OV        11
`define SFCF_C_UV        10
`define SFCF_A_OSC       9
`define SFCF_IO_OSC      8
`define SFCF_C_OSC       7
`define SFCF_A_HOT       6
`define SFCF_IO_HOT      5
`define SFCF_A_LIM       4
`define SFCF_IO_LIM      3
`define SFCF_GA_OPEN     2
`define SFCF_GB_OPEN     1
`define SFCF_GD_OPEN     0

// ==========================================================
// clock flag bit positions
`define SFCF_MCK_FREQ    2
`define SFCF_DOSC_WD     1
`define SFCF_MCK_WD      0

`endif

/* core/sfcf_pkg.sv */
`include "sfcf_defs.svh"

package sfcf_pkg;

    // ==========================================================
    // whole state of the flag bank
    typedef struct packed {
        logic [`SFCF_NEV-1:0]  sync1;
        logic [`SFCF_NEV-1:0]  sync2;
        logic [`SFCF_NEV-1:0]  sync3;
        logic [`SFCF_NSUP-1:0] supply;
        logic [`SFCF_NCLK-1:0] clock;
        logic [`SFCF_NEV-1:0]  irq_status;
        logic [`SFCF_NEV-1:0]  irq_mask;
        logic [31:0]           rdata;
    } sfcf_state_s;

endpackage : sfcf_pkg

/* verif/sfcf_flags_asserts.sv */
`timescale 1ns/1ps
`include "sfcf_defs.svh"

module sfcf_flags_chk (
    // bus
    input wire logic                 pclk,
    input wire logic                 presetn,
    input wire logic                 psel,
    input wire logic                 penable,
    input wire logic                 pwrite,
    input wire logic [`SFCF_AW-1:0]  paddr,
    input wire logic [31:0]          pwdata,
    input wire logic [3:0]           pstrb,
    input wire logic [31:0]          prdata,
    input wire logic                 pready,
    input wire logic                 pslverr,
    // detectors
    input wire logic                 analog_supply_overvoltage_n,
    input wire logic                 main_clock_watchdog_n
);
    default clocking @(posedge pclk); endclocking
    default disable iff (!presetn);

    // ====
    // decoded bus phases
    wire logic acc    = psel && penable;
    wire logic mapped = paddr inside {`SFCF_SUP_ADDR, `SFCF_CLK_ADDR, `SFCF_IRQ_ADDR, `SFCF_MSK_ADDR};
    wire logic sup_rd = psel && !penable && !pwrite && paddr == `SFCF_SUP_ADDR;
    wire logic clk_rd = psel && !penable && !pwrite && paddr == `SFCF_CLK_ADDR;
    wire logic sup_w1 = acc && pwrite && paddr == `SFCF_SUP_ADDR && pwdata[15] && pstrb[1];
    wire logic clk_w1 = acc && pwrite && paddr == `SFCF_CLK_ADDR && pwdata[0] && pstrb[0];

    // ====
    // properties
    ready_always_a: assert property (pready) else $error("pready low");
    bad_addr_a: assert property (acc && !mapped |-> pslverr) else $error("no error on unmapped");
    good_addr_a: assert property (!(acc && !mapped) |-> !pslverr) else $error("spurious error");
    clk_pattern_a: assert property (clk_rd ##1 acc |-> prdata[31:3] == 29'h1f80)
        else $error("clock reserved bits wrong");
    // six low samples cover the worst synchroniser latency
    ov_drop_a: assert property ((!analog_supply_overvoltage_n)[*6] ##0 sup_rd ##1 acc |-> !prdata[15])
        else $error("overvoltage flag not low");
    wd_drop_a: assert property ((!main_clock_watchdog_n)[*6] ##0 clk_rd ##1 acc |-> !prdata[0])
        else $error("watchdog flag not low");
    ov_clear_a: assert property (
        analog_supply_overvoltage_n[*4] ##0 sup_w1 ##1 sup_rd ##1 acc |-> prdata[15])
        else $error("overvoltage flag not cleared");
    wd_clear_a: assert property (main_clock_watchdog_n[*4] ##0 clk_w1 ##1 clk_rd ##1 acc |-> prdata[0])
        else $error("watchdog flag not cleared");
endmodule : sfcf_flags_chk

bind sfcf_flags sfcf_flags_chk sfcf_flags_chk_inst (.pclk(pclk), .presetn(presetn), .psel(psel),
    .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .pstrb(pstrb), .prdata(prdata),
    .pready(pready), .pslverr(pslverr), .analog_supply_overvoltage_n(analog_supply_overvoltage_n),
    .main_clock_watchdog_n(main_clock_watchdog_n));

/* verif/supply_clock_fault_flags_bench.sv */
`timescale 1ns/1ps
`include "sfcf_defs.svh"

module supply_clock_fault_flags_bench;
    logic        pclk    = 1'b0;
    logic        presetn = 1'b0;
    logic        psel    = 1'b0;
    logic        penable = 1'b0;
    logic        pwrite  = 1'b0;
    logic [7:0]  paddr   = 8'h00;
    logic [31:0] pwdata  = 32'h0;
    logic [3:0]  pstrb   = 4'h0;
    logic [3:0]  strb    = 4'hf;
    logic [18:0] flt_n   = 19'h7ffff;
    logic [31:0] prdata;
    logic        pready;
    logic        pslverr;
    logic        irq;
    logic [31:0] sup_e;
    logic [31:0] clk_e;
    int          error_cnt  = 0;
    int          num_checks = 0;
    int          cyc        = 0;

    always #2 pclk = ~pclk;

    sfcf_flags sfcf_flags_inst (
        .pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr),
        .pwdata(pwdata), .pstrb(pstrb), .prdata(prdata), .pready(pready), .pslverr(pslverr), .irq(irq),
        .analog_supply_overvoltage_n(flt_n[15]), .analog_supply_undervoltage_n(flt_n[14]),
        .io_supply_overvoltage_n(flt_n[13]), .io_supply_undervoltage_n(flt_n[12]),
        .core_supply_overvoltage_n(flt_n[11]), .core_supply_undervoltage_n(flt_n[10]),
        .analog_supply_oscillation_n(flt_n[9]), .io_supply_oscillation_n(flt_n[8]),
        .core_supply_oscillation_n(flt_n[7]), .analog_regulator_hot_n(flt_n[6]), .io_regulator_hot_n(flt_n[5]),
        .analog_regulator_limit_n(flt_n[4]), .io_regulator_limit_n(flt_n[3]), .ground_a_open_n(flt_n[2]),
        .ground_b_open_n(flt_n[1]), .digital_ground_open_n(flt_n[0]), .main_clock_freq_fault_n(flt_n[18]),
        .diag_oscillator_watchdog_n(flt_n[17]), .main_clock_watchdog_n(flt_n[16])
    );

    task automatic conclude();
        $display("checks %0d errors %0d", num_checks, error_cnt);
        if (error_cnt == 0 && num_checks > 0)
            $display("TEST PASSED");
        else
            $display("TEST FAILED");
        $finish;
    endtask : conclude

    task automatic check(input logic [31:0] got, input logic [31:0] exp);
        num_checks++;
        if (got !== exp) begin
            error_cnt++;
            $display("ERROR %0t: got %h expected %h", $time, got, exp);
        end
    endtask : check

    // ====
    // apb transfer; for reads d is the expected data, request left up for back-to-back use
    task automatic xfer(input logic [7:0] a, input logic w, input logic [31:0] d, input logic err);
        psel <= 1'b1;
        penable <= 1'b0;
        pwrite <= w;
        paddr <= a;
        pwdata <= d;
        pstrb <= strb;
        @(posedge pclk);
        penable <= 1'b1;
        @(posedge pclk);
        // ends when pready is high; if it never rises, only the bench timeout ends this wait
        while (pready !== 1'b1) begin
            @(posedge pclk);
        end
        check({31'h0, pslverr}, {31'h0, err});
        if (!w)
            check(prdata, d);
    endtask : xfer

    task automatic idle(input int n);
        psel <= 1'b0;
        penable <= 1'b0;
        repeat (n) @(posedge pclk);
    endtask : idle

    task automatic clear_all();
        xfer(`SFCF_IRQ_ADDR, 1'b1, 32'h7ffff, 1'b0);
        xfer(`SFCF_SUP_ADDR, 1'b1, 32'hffff, 1'b0);
        xfer(`SFCF_SUP_ADDR, 1'b0, 32'hffff, 1'b0);
        xfer(`SFCF_CLK_ADDR, 1'b1, 32'h7, 1'b0);
        xfer(`SFCF_CLK_ADDR, 1'b0, 32'hfc07, 1'b0);
        idle(1);
        check({31'h0, irq}, 32'h0);
    endtask : clear_all

    always @(posedge pclk) begin
        cyc <= cyc + 1;
        if (cyc == 5000) begin
            error_cnt++;
            $display("ERROR %0t: timeout", $time);
            conclude();
        end
    end

    initial begin
        repeat (6) @(posedge pclk);
        presetn <= 1'b1;
        @(posedge pclk);
        xfer(`SFCF_SUP_ADDR, 1'b0, 32'hffff, 1'b0);
        xfer(`SFCF_CLK_ADDR, 1'b0, 32'hfc07, 1'b0);
        xfer(8'h30, 1'b0, 32'h0, 1'b1);
        xfer(`SFCF_CLK_ADDR, 1'b1, 32'hffff_fff8, 1'b0);
        xfer(`SFCF_CLK_ADDR, 1'b0, 32'hfc07, 1'b0);
        xfer(`SFCF_MSK_ADDR, 1'b1, 32'h7ffff, 1'b0);
        for (int i = 0; i < 19; i++) begin
            flt_n[i] <= 1'b0;
            idle(6);
            flt_n[i] <= 1'b1;
            idle(6);
            sup_e = (i < 16) ? 32'hffff & ~(32'h1 << i) : 32'hffff;
            clk_e = (i < 16) ? 32'hfc07 : 32'hfc07 & ~(32'h1 << (i - 16));
            check({31'h0, irq}, 32'h1);
            xfer(`SFCF_SUP_ADDR, 1'b1, 32'h0, 1'b0);
            xfer(`SFCF_SUP_ADDR, 1'b0, sup_e, 1'b0);
            xfer(`SFCF_CLK_ADDR, 1'b0, clk_e, 1'b0);
            xfer(`SFCF_IRQ_ADDR, 1'b0, 32'h1 << i, 1'b0);
            clear_all();
        end
        // masked events still latch status but keep irq quiet
        xfer(`SFCF_MSK_ADDR, 1'b1, 32'h0, 1'b0);
        for (int i = 15; i < 17; i++) begin
            flt_n[i] <= 1'b0;
            idle(6);
            check({31'h0, irq}, 32'h0);
            xfer(`SFCF_SUP_ADDR, 1'b1, 32'hffff, 1'b0);
            xfer(`SFCF_CLK_ADDR, 1'b1, 32'h7, 1'b0);
            xfer(`SFCF_SUP_ADDR, 1'b0, (i == 15) ? 32'h7fff : 32'hffff, 1'b0);
            xfer(`SFCF_CLK_ADDR, 1'b0, (i == 15) ? 32'hfc07 : 32'hfc06, 1'b0);
            xfer(`SFCF_IRQ_ADDR, 1'b0, 32'h1 << i, 1'b0);
            flt_n[i] <= 1'b1;
            idle(6);
            clear_all();
        end
        // a one written on a disabled byte lane must not restore the flag
        flt_n[15] <= 1'b0;
        idle(6);
        flt_n[15] <= 1'b1;
        idle(6);
        strb = 4'h1;
        xfer(`SFCF_SUP_ADDR, 1'b1, 32'hffff, 1'b0);
        strb = 4'hf;
        xfer(`SFCF_SUP_ADDR, 1'b0, 32'h7fff, 1'b0);
        // reset in mid-run returns every flag and status bit to idle
        presetn <= 1'b0;
        idle(2);
        presetn <= 1'b1;
        @(posedge pclk);
        xfer(`SFCF_SUP_ADDR, 1'b0, 32'hffff, 1'b0);
        xfer(`SFCF_CLK_ADDR, 1'b0, 32'hfc07, 1'b0);
        xfer(`SFCF_IRQ_ADDR, 1'b0, 32'h0, 1'b0);
        conclude();
    end
endmodule : supply_clock_fault_flags_bench
